// ### rtl/dpa_adc_seq.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_adc_seq #(
    parameter int FIRST_US    = dpa_pkg::FIRST_US,
    parameter int PER_SLOW_US = dpa_pkg::PER_SLOW_US,
    parameter int PER_FAST_US = dpa_pkg::PER_FAST_US,
    parameter int DW          = 16
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          enable_i,
    input  wire logic          start_i,
    input  wire logic          cal_i,
    input  wire logic          rate_fast_i,
    input  wire logic [DW-1:0] raw_i,
    input  wire logic [DW-1:0] offset_i,
    output logic      [DW-1:0] data_o,
    output logic               data_ready_o,
    output logic      [DW-1:0] cal_offset_o,
    output logic               cal_done_o,
    output dpa_pkg::dpa_seq_t  state_o
);

    localparam int WW = $clog2(FIRST_US + 1);
    localparam int UW = $clog2(dpa_pkg::US_CYC);
    localparam logic [UW-1:0] US_LAST    = UW'(dpa_pkg::US_CYC - 1);
    localparam logic [WW-1:0] FIRST_LAST = WW'(FIRST_US - 1);
    localparam logic [WW-1:0] SLOW_LAST  = WW'(PER_SLOW_US - 1);
    localparam logic [WW-1:0] FAST_LAST  = WW'(PER_FAST_US - 1);

    ////////////////////////////////////////////////////////////////////////////
    // microsecond enable and interval counter
    logic [UW-1:0]     us_cnt_r;
    logic [WW-1:0]     wait_r;
    dpa_pkg::dpa_seq_t state_r;
    dpa_pkg::dpa_seq_t state_nxt;

    wire           us_tick   = (us_cnt_r == US_LAST);
    wire [WW-1:0]  per_last  = rate_fast_i ? FAST_LAST : SLOW_LAST;
    wire           first_end = us_tick && (wait_r == FIRST_LAST);
    wire           per_end   = us_tick && (wait_r == per_last);
    wire [DW-1:0]  corrected = raw_i - offset_i; // RQ12
    wire           restart   = start_i && enable_i;
    wire           conv_now  = (state_r == dpa_pkg::SEQ_FIRST && first_end) ||
                               (state_r == dpa_pkg::SEQ_CONV && per_end);
    wire           cal_now   = (state_r == dpa_pkg::SEQ_CAL) && first_end;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dpa_pkg::SEQ_OFF:   state_nxt = dpa_pkg::SEQ_OFF;
            dpa_pkg::SEQ_FIRST: if (first_end) state_nxt = dpa_pkg::SEQ_CONV; // RQ7
            dpa_pkg::SEQ_CONV:  state_nxt = dpa_pkg::SEQ_CONV; // RQ8
            dpa_pkg::SEQ_CAL:   if (first_end) state_nxt = dpa_pkg::SEQ_OFF; // RQ10
            default:            state_nxt = dpa_pkg::SEQ_OFF;
        endcase
        if (restart) begin
            state_nxt = cal_i ? dpa_pkg::SEQ_CAL : dpa_pkg::SEQ_FIRST;
        end
        if (!enable_i) begin
            state_nxt = dpa_pkg::SEQ_OFF; // RQ18
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart || state_r == dpa_pkg::SEQ_OFF) begin
            us_cnt_r <= '0;
        end else begin
            us_cnt_r <= us_tick ? '0 : us_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart || conv_now || state_r == dpa_pkg::SEQ_OFF) begin
            wait_r <= '0;
        end else if (us_tick) begin
            wait_r <= wait_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // results
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r      <= dpa_pkg::SEQ_OFF;
            data_o       <= '0;
            data_ready_o <= 1'b0;
            cal_offset_o <= '0;
            cal_done_o   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            data_ready_o <= conv_now && enable_i && !restart;
            cal_done_o   <= cal_now && enable_i && !restart;
            if (conv_now && enable_i && !restart) begin
                data_o <= corrected; // RQ12
            end
            if (cal_now && enable_i && !restart) begin
                cal_offset_o <= raw_i; // RQ11
            end
        end
    end

    assign state_o = state_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    seq_start_conv_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ7
        enable_i && start_i && !cal_i |=> state_r == dpa_pkg::SEQ_FIRST && !data_ready_o)
        else $error("start did not enter first-result wait");

    seq_start_cal_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ10
        enable_i && start_i && cal_i |=> state_r == dpa_pkg::SEQ_CAL)
        else $error("calibration request did not enter calibration");

    seq_cal_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ10
        cal_done_o |-> state_r == dpa_pkg::SEQ_OFF && $past(state_r) == dpa_pkg::SEQ_CAL)
        else $error("calibration did not stop the sequencer");

    seq_data_sub_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ12
        data_ready_o |-> data_o == $past(raw_i) - $past(offset_i))
        else $error("result not offset corrected");

    seq_power_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ18
        !enable_i |=> state_r == dpa_pkg::SEQ_OFF && !data_ready_o && $stable(data_o))
        else $error("sequencer ran without adc power");

    seq_us_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        us_tick |=> us_cnt_r == '0)
        else $error("microsecond divider overran");

endmodule // dpa_adc_seq
`default_nettype wire

// ### rtl/dpa_pkg.sv
// Summary of operation
// [RQ1] each power mode enables a fixed set of blocks; run enables everything
// [RQ2] wake-up event powers standby-level blocks, leaves the others untouched
// [RQ3] after power-up adc control selects normal conversion at the slow rate
// [RQ4] adc defaults: gain one third, input buffers off, unipolar polarity
// [RQ5] host enters run, writes mux, then writes adc control with start
// [RQ6] mux value 94h routes input a positive and input b negative
// [RQ7] first conversion result is ready 100 ms after the start write
// [RQ8] conversions then repeat at the selected rate until powered down
// [RQ9] host requests calibration by writing mode bit and start bit set
// [RQ10] calibration runs once on the selected inputs, then converting stops
// [RQ11] calibration result lands in the offset register as two's complement
// [RQ12] every later result has the offset subtracted before storing
// [RQ13] calibration completion clears the mode bit automatically
// [RQ14] host may write a saved offset back instead of recalibrating
// [RQ15] commands 11010, 11011, 11100 enter sleep, standby, idle without data
// [RQ16] command 11101 enters run mode without data
// [RQ17] in sleep a low wake input or an alarm moves to standby
// [RQ18] leaving run stops the sequencer and holds data until a new start
package dpa_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ        = 40_000_000;
    localparam int US_CYC        = CLK_HZ / 1_000_000;
    localparam int T_FIRST_MS    = 100;
    localparam int RATE_SLOW_HZ  = 30;
    localparam int RATE_FAST_HZ  = 60;
    localparam int FIRST_US      = T_FIRST_MS * 1000;
    localparam int PER_SLOW_US   = 1_000_000 / RATE_SLOW_HZ;
    localparam int PER_FAST_US   = 1_000_000 / RATE_FAST_HZ;

    ////////////////////////////////////////////////////////////////////////////
    // command addresses
    localparam logic [4:0] CMD_SLEEP = 5'h1a;
    localparam logic [4:0] CMD_STBY  = 5'h1b;
    localparam logic [4:0] CMD_IDLE  = 5'h1c;
    localparam logic [4:0] CMD_RUN   = 5'h1d;

    localparam logic [7:0] MUX_A_POS_B_NEG = 8'h94;

    typedef enum logic [1:0] {
        DPA_SLEEP = 2'h0,
        DPA_STBY  = 2'h1,
        DPA_IDLE  = 2'h3,
        DPA_RUN   = 2'h2
    } dpa_mode_t;

    typedef struct packed {
        logic serial_port;
        logic wake_logic;
        logic xtal_osc;
        logic rtc_alarm;
        logic reset_mon;
        logic low_vdd_mon;
        logic master_bias;
        logic pll;
        logic pll_clock_output;
        logic ext_supply_off_ctrl;
        logic dac1;
        logic dac2;
        logic bandgap;
        logic bandgap_buf;
        logic sig_detect_cmp;
        logic adc_mux;
        logic adc_in_buf;
        logic adc;
    } dpa_pwr_t;

    localparam dpa_pwr_t PWR_SLEEP = 18'h3e000;
    localparam dpa_pwr_t PWR_STBY  = 18'h3ff00;
    localparam dpa_pwr_t PWR_IDLE  = 18'h3fffc;
    localparam dpa_pwr_t PWR_RUN   = 18'h3ffff;

    typedef struct packed {
        logic       polarity_select;
        logic       neg_input_buffer_en;
        logic       pos_input_buffer_en;
        logic [1:0] gain;
        logic       rate_fast;
        logic       cal_mode;
        logic       start_bit_one;
    } dpa_adc_cfg_t;

    localparam dpa_adc_cfg_t ADC_CFG_RST = 8'h00;

    typedef enum logic [1:0] {
        SEQ_OFF   = 2'h0,
        SEQ_FIRST = 2'h1,
        SEQ_CONV  = 2'h3,
        SEQ_CAL   = 2'h2
    } dpa_seq_t;

endpackage

// ### rtl/dpa_power_adc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_power_adc_ctrl #(
    parameter int FIRST_US    = dpa_pkg::FIRST_US,
    parameter int PER_SLOW_US = dpa_pkg::PER_SLOW_US,
    parameter int PER_FAST_US = dpa_pkg::PER_FAST_US,
    parameter int DW          = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             cmd_valid_i,
    input  wire logic [4:0]       cmd_addr_i,
    input  wire logic             mux_wr_i,
    input  wire logic [7:0]       mux_data_i,
    input  wire logic             adc_wr_i,
    input  wire logic [7:0]       adc_data_i,
    input  wire logic             offset_wr_i,
    input  wire logic [DW-1:0]    offset_data_i,
    input  wire logic             wake_input_a_n_i,
    input  wire logic             wake_input_b_n_i,
    input  wire logic             alarm_i,
    input  wire logic [DW-1:0]    raw_result_i,
    output dpa_pkg::dpa_mode_t    mode_o,
    output dpa_pkg::dpa_pwr_t     pwr_o,
    output dpa_pkg::dpa_adc_cfg_t adc_cfg_o,
    output logic      [7:0]       mux_o,
    output logic                  route_a_pos_b_neg_o,
    output logic      [DW-1:0]    offset_o,
    output logic      [DW-1:0]    data_o,
    output logic                  data_ready_o,
    output logic                  cal_busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // wake pin synchronisers, a change counts once stages two and three agree
    logic [2:0] wa_s_r;
    logic [2:0] wb_s_r;
    logic       wa_st_r;
    logic       wb_st_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wa_s_r  <= 3'h7;
            wb_s_r  <= 3'h7;
            wa_st_r <= 1'b1;
            wb_st_r <= 1'b1;
        end else begin
            wa_s_r <= {wa_s_r[1:0], wake_input_a_n_i};
            wb_s_r <= {wb_s_r[1:0], wake_input_b_n_i};
            if (wa_s_r[1] == wa_s_r[2]) wa_st_r <= wa_s_r[2];
            if (wb_s_r[1] == wb_s_r[2]) wb_st_r <= wb_s_r[2];
        end
    end

    wire wa_fall  = wa_st_r && (wa_s_r[1] == wa_s_r[2]) && !wa_s_r[2];
    wire wb_fall  = wb_st_r && (wb_s_r[1] == wb_s_r[2]) && !wb_s_r[2];
    wire wake_evt = wa_fall || wb_fall || alarm_i;

    ////////////////////////////////////////////////////////////////////////////
    // mode command decode
    function automatic logic cmd_is_mode(input logic [4:0] a);
        cmd_is_mode = (a == dpa_pkg::CMD_SLEEP) || (a == dpa_pkg::CMD_STBY) ||
                      (a == dpa_pkg::CMD_IDLE) || (a == dpa_pkg::CMD_RUN);
    endfunction

    function automatic dpa_pkg::dpa_mode_t cmd_mode(input logic [4:0] a);
        case (a)
            dpa_pkg::CMD_SLEEP: cmd_mode = dpa_pkg::DPA_SLEEP;
            dpa_pkg::CMD_IDLE:  cmd_mode = dpa_pkg::DPA_IDLE;
            dpa_pkg::CMD_RUN:   cmd_mode = dpa_pkg::DPA_RUN;
            default:            cmd_mode = dpa_pkg::DPA_STBY;
        endcase
    endfunction

    function automatic dpa_pkg::dpa_pwr_t mode_pwr(input dpa_pkg::dpa_mode_t m);
        case (m)
            dpa_pkg::DPA_SLEEP: mode_pwr = dpa_pkg::PWR_SLEEP;
            dpa_pkg::DPA_IDLE:  mode_pwr = dpa_pkg::PWR_IDLE;
            dpa_pkg::DPA_RUN:   mode_pwr = dpa_pkg::PWR_RUN;
            default:            mode_pwr = dpa_pkg::PWR_STBY;
        endcase
    endfunction

    wire                     cmd_hit  = cmd_valid_i && cmd_is_mode(cmd_addr_i); // RQ15 RQ16
    wire dpa_pkg::dpa_mode_t cmd_m    = cmd_mode(cmd_addr_i);
    wire dpa_pkg::dpa_pwr_t  wake_pwr = pwr_o | dpa_pkg::PWR_STBY; // RQ2

    dpa_pkg::dpa_mode_t mode_nxt;
    dpa_pkg::dpa_pwr_t  pwr_nxt;

    always_comb begin
        mode_nxt = mode_o;
        pwr_nxt  = pwr_o;
        if (cmd_hit) begin
            mode_nxt = cmd_m;
            pwr_nxt  = mode_pwr(cmd_m); // RQ1
        end else if (wake_evt) begin
            pwr_nxt = wake_pwr; // RQ2
            if (mode_o == dpa_pkg::DPA_SLEEP) begin
                mode_nxt = dpa_pkg::DPA_STBY; // RQ17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // adc sequencer
    logic [DW-1:0]     cal_off;
    logic              cal_done;
    logic              seq_ready;
    logic [DW-1:0]     seq_data;
    dpa_pkg::dpa_seq_t seq_state;

    wire dpa_pkg::dpa_adc_cfg_t wr_cfg = adc_data_i;
    wire start = adc_wr_i && wr_cfg.start_bit_one; // RQ5 RQ9

    dpa_adc_seq #(
        .FIRST_US    (FIRST_US),
        .PER_SLOW_US (PER_SLOW_US),
        .PER_FAST_US (PER_FAST_US),
        .DW          (DW)
    ) u_seq (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .enable_i     (pwr_o.adc),
        .start_i      (start),
        .cal_i        (wr_cfg.cal_mode),
        .rate_fast_i  (adc_cfg_o.rate_fast),
        .raw_i        (raw_result_i),
        .offset_i     (offset_o),
        .data_o       (seq_data),
        .data_ready_o (seq_ready),
        .cal_offset_o (cal_off),
        .cal_done_o   (cal_done),
        .state_o      (seq_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_o              <= dpa_pkg::DPA_STBY;
            pwr_o               <= dpa_pkg::PWR_STBY;
            adc_cfg_o           <= dpa_pkg::ADC_CFG_RST; // RQ3 RQ4
            mux_o               <= '0;
            route_a_pos_b_neg_o <= 1'b0;
            offset_o            <= '0;
            data_o              <= '0;
            data_ready_o        <= 1'b0;
            cal_busy_o          <= 1'b0;
        end else begin
            mode_o       <= mode_nxt;
            pwr_o        <= pwr_nxt;
            data_ready_o <= seq_ready;
            cal_busy_o   <= (seq_state == dpa_pkg::SEQ_CAL);
            if (seq_ready) data_o <= seq_data; // RQ18
            if (adc_wr_i) begin
                adc_cfg_o <= wr_cfg;
            end else if (cal_done) begin
                adc_cfg_o.cal_mode <= 1'b0; // RQ13
            end
            if (mux_wr_i) begin
                mux_o               <= mux_data_i;
                route_a_pos_b_neg_o <= (mux_data_i == dpa_pkg::MUX_A_POS_B_NEG); // RQ6
            end
            if (offset_wr_i) begin
                offset_o <= offset_data_i; // RQ14
            end else if (cal_done) begin
                offset_o <= cal_off; // RQ11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    top_reset_dflt_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ3
        !$past(rst_n_i) |-> adc_cfg_o == dpa_pkg::ADC_CFG_RST && mode_o == dpa_pkg::DPA_STBY)
        else $error("reset defaults wrong");

    mode_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ1
        cmd_valid_i && cmd_addr_i == dpa_pkg::CMD_IDLE |=>
            mode_o == dpa_pkg::DPA_IDLE && pwr_o == dpa_pkg::PWR_IDLE)
        else $error("idle command not applied");

    run_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ16
        cmd_valid_i && cmd_addr_i == dpa_pkg::CMD_RUN |=> pwr_o == dpa_pkg::PWR_RUN)
        else $error("run command not applied");

    wake_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ2
        wake_evt && !cmd_hit |=> (pwr_o & dpa_pkg::PWR_STBY) == dpa_pkg::PWR_STBY &&
            (pwr_o & ~dpa_pkg::PWR_STBY) == ($past(pwr_o) & ~dpa_pkg::PWR_STBY))
        else $error("wake event changed other blocks");

    sleep_wake_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ17
        mode_o == dpa_pkg::DPA_SLEEP && alarm_i && !cmd_valid_i |=> mode_o == dpa_pkg::DPA_STBY)
        else $error("alarm did not leave sleep");

    cal_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ13
        cal_done && !adc_wr_i |=> !adc_cfg_o.cal_mode)
        else $error("mode bit not cleared after calibration");

    cal_store_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ11
        cal_done && !offset_wr_i |=> offset_o == $past(cal_off))
        else $error("calibration offset not stored");

    mux_route_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ6
        mux_wr_i |=> route_a_pos_b_neg_o == ($past(mux_data_i) == dpa_pkg::MUX_A_POS_B_NEG))
        else $error("mux route flag wrong");

endmodule // dpa_power_adc_ctrl
`default_nettype wire

// ### sim/das_power_mode_adc_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module das_power_mode_adc_sequencer_tb;
    localparam int F_CYC  = 5 * 40;
    localparam int PS_CYC = 3 * 40;
    localparam int PF_CYC = 2 * 40;

    logic                  sys_clk_i;
    logic                  rst_n_i;
    logic                  wake_a_n;
    logic                  wake_b_n;
    logic                  alarm;
    logic [15:0]           raw;
    logic                  cmd_valid;
    logic [4:0]            cmd_addr;
    logic                  mux_wr;
    logic [7:0]            mux_data;
    logic                  adc_wr;
    logic [7:0]            adc_data;
    logic                  off_wr;
    logic [15:0]           off_data;
    dpa_pkg::dpa_mode_t    mode;
    dpa_pkg::dpa_pwr_t     pwr;
    dpa_pkg::dpa_adc_cfg_t cfg;
    logic [7:0]            mux;
    logic                  route;
    logic [15:0]           offset;
    logic [15:0]           data;
    logic                  ready;
    logic                  cal_busy;
    int                    n_mismatch;
    int                    check_count;
    int                    n;
    int                    k;
    logic [19:0]           exp_st;
    logic [15:0]           rc;
    logic [4:0]            a;
    logic [4:0]            cmds [6] = '{5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1c, 5'h1a};

    dpa_host_model host (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid), .cmd_addr_o(cmd_addr),
        .mux_wr_o(mux_wr), .mux_data_o(mux_data), .adc_wr_o(adc_wr), .adc_data_o(adc_data),
        .offset_wr_o(off_wr), .offset_data_o(off_data));

    dpa_power_adc_ctrl #(.FIRST_US(5), .PER_SLOW_US(3), .PER_FAST_US(2)) uut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
        .cmd_addr_i(cmd_addr), .mux_wr_i(mux_wr), .mux_data_i(mux_data), .adc_wr_i(adc_wr),
        .adc_data_i(adc_data), .offset_wr_i(off_wr), .offset_data_i(off_data),
        .wake_input_a_n_i(wake_a_n), .wake_input_b_n_i(wake_b_n), .alarm_i(alarm),
        .raw_result_i(raw), .mode_o(mode), .pwr_o(pwr), .adc_cfg_o(cfg), .mux_o(mux),
        .route_a_pos_b_neg_o(route), .offset_o(offset), .data_o(data),
        .data_ready_o(ready), .cal_busy_o(cal_busy));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [19:0] exp_mode(input logic [4:0] c);
        case (c)
            dpa_pkg::CMD_SLEEP: exp_mode = {dpa_pkg::DPA_SLEEP, dpa_pkg::PWR_SLEEP};
            dpa_pkg::CMD_STBY:  exp_mode = {dpa_pkg::DPA_STBY, dpa_pkg::PWR_STBY};
            dpa_pkg::CMD_IDLE:  exp_mode = {dpa_pkg::DPA_IDLE, dpa_pkg::PWR_IDLE};
            default:            exp_mode = {dpa_pkg::DPA_RUN, dpa_pkg::PWR_RUN};
        endcase
    endfunction

    task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_time(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wait_ready(output int c);
        c = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            c++;
        end while (ready !== 1'b1 && c < 1000);
        if (ready !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] t=%0t ready timeout got=%h exp=%h", $time, ready, 1'b1);
        end
    endtask

    task automatic count_ready(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge sys_clk_i);
            #1;
            if (ready === 1'b1) c++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_mismatch++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        wake_a_n = 1'b1;
        wake_b_n = 1'b1;
        alarm = 1'b0;
        raw = 16'h0000;
        void'($urandom(92));
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_val({cfg, mux, offset == 16'h0000}, 20'h00001);
        chk_val({mode, pwr}, {dpa_pkg::DPA_STBY, dpa_pkg::PWR_STBY});
        $display("test reset done");
        foreach (cmds[i]) begin
            host.send_cmd(cmds[i]);
            #1;
            exp_st = exp_mode(cmds[i]);
            chk_val({mode, pwr}, exp_st);
            a = 5'($urandom_range(25, 0));
            host.send_cmd(a);
            #1;
            chk_val({mode, pwr}, exp_st);
        end
        $display("test modes done");
        @(posedge sys_clk_i);
        alarm <= 1'b1;
        @(posedge sys_clk_i);
        alarm <= 1'b0;
        #1;
        chk_val({mode, pwr}, exp_mode(dpa_pkg::CMD_STBY));
        host.send_cmd(dpa_pkg::CMD_SLEEP);
        wake_a_n <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk_val({mode, pwr}, exp_mode(dpa_pkg::CMD_STBY));
        wake_a_n <= 1'b1;
        host.send_cmd(dpa_pkg::CMD_IDLE);
        wake_b_n <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk_val({mode, pwr}, exp_mode(dpa_pkg::CMD_IDLE));
        wake_b_n <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        $display("test wake done");
        raw <= 16'($urandom);
        host.start_conv(dpa_pkg::MUX_A_POS_B_NEG, 8'h01);
        #1;
        chk_val({route, mux, cfg}, {1'b1, 8'h94, 8'h01});
        wait_ready(n);
        chk_time(n, F_CYC - 2, F_CYC + 3);
        chk_val(data, raw);
        raw <= 16'($urandom);
        wait_ready(n);
        chk_time(n, PS_CYC - 1, PS_CYC + 1);
        chk_val(data, raw);
        host.write_adc(8'h05);
        wait_ready(n);
        wait_ready(n);
        chk_time(n, PF_CYC - 1, PF_CYC + 1);
        $display("test conversion done");
        rc = 16'($urandom) | 16'h8000;
        raw <= rc;
        host.calibrate();
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk_val(cal_busy, 1'b1);
        k = 0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (ready === 1'b1) k++;
        end while (cfg.cal_mode !== 1'b0 && n < 1000);
        chk_val(offset, rc);
        chk_val(cfg.cal_mode, 1'b0);
        count_ready(300, n);
        chk_val(k + n, 0);
        raw <= 16'($urandom);
        host.write_adc(8'h01);
        wait_ready(n);
        chk_val(data, 16'(raw - rc));
        $display("test calibration done");
        rc = 16'($urandom);
        host.restore_offset(rc);
        raw <= 16'($urandom);
        #1;
        chk_val(offset, rc);
        wait_ready(n);
        chk_val(data, 16'(raw - rc));
        exp_st = {4'h0, 16'(raw - rc)};
        host.send_cmd(dpa_pkg::CMD_IDLE);
        raw <= ~raw;
        count_ready(300, n);
        chk_val(n, 0);
        chk_val({4'h0, data}, exp_st);
        host.send_cmd(dpa_pkg::CMD_RUN);
        count_ready(300, n);
        chk_val(n, 0);
        $display("test stop done");
        final_report();
    end
endmodule // das_power_mode_adc_sequencer_tb
`default_nettype wire

// ### sim/dpa_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpa_host_model (
    input  wire logic        sys_clk_i,
    output logic             cmd_valid_o,
    output logic [4:0]       cmd_addr_o,
    output logic             mux_wr_o,
    output logic [7:0]       mux_data_o,
    output logic             adc_wr_o,
    output logic [7:0]       adc_data_o,
    output logic             offset_wr_o,
    output logic [15:0]      offset_data_o
);
    ////////////////////////////////////////////////////////////////////////////
    // idle levels
    initial begin
        cmd_valid_o   = 1'b0;
        cmd_addr_o    = 5'h00;
        mux_wr_o      = 1'b0;
        mux_data_o    = 8'h00;
        adc_wr_o      = 1'b0;
        adc_data_o    = 8'h00;
        offset_wr_o   = 1'b0;
        offset_data_o = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command byte: address only, no data bits
    task automatic send_cmd(input logic [4:0] a);
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_addr_o  <= a;
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_addr_o  <= ~a;
    endtask

    task automatic write_mux(input logic [7:0] d);
        @(posedge sys_clk_i);
        mux_wr_o   <= 1'b1;
        mux_data_o <= d;
        @(posedge sys_clk_i);
        mux_wr_o   <= 1'b0;
        mux_data_o <= ~d;
    endtask

    task automatic write_adc(input logic [7:0] d);
        @(posedge sys_clk_i);
        adc_wr_o   <= 1'b1;
        adc_data_o <= d;
        @(posedge sys_clk_i);
        adc_wr_o   <= 1'b0;
        adc_data_o <= ~d;
    endtask

    // saved offset written back instead of recalibrating
    task automatic restore_offset(input logic [15:0] d);
        @(posedge sys_clk_i);
        offset_wr_o   <= 1'b1;
        offset_data_o <= d;
        @(posedge sys_clk_i);
        offset_wr_o   <= 1'b0;
        offset_data_o <= ~d;
    endtask

    // run, then mux, then adc control with start
    task automatic start_conv(input logic [7:0] m, input logic [7:0] c);
        send_cmd(dpa_pkg::CMD_RUN);
        write_mux(m);
        write_adc(c);
    endtask

    // mode bit and first start bit both set
    task automatic calibrate();
        write_adc(8'h03);
    endtask
endmodule // dpa_host_model
`default_nettype wire
